// >>> shared/hfc_consts.svh
`ifndef HFC_CONSTS_SVH
`define HFC_CONSTS_SVH
`define HFC_RT_SET 8'h21
`define HFC_RT_GET 8'ha1
`define HFC_RQ_SET 8'h09
`define HFC_RQ_GET 8'h01
`define HFC_VAL_HI_FEATURE 8'h03
`define HFC_TAG_CMD 8'h03
`define HFC_TAG_PARAM 8'h05
`define HFC_TAG_STATUS 8'h06
`define HFC_SUB_SET_PARAM 8'h01
`define HFC_SUB_SEL_PARAM 8'h02
`define HFC_SUB_RESET 8'h07
`define HFC_SUB_DEFAULTS 8'h08
`define HFC_AREA_NV 8'h00
`define HFC_BLOCK_NUM 8'h05
`define HFC_BLOCK_OFS 8'h00
`define HFC_VALID_CNT 8'h04
`define HFC_LEN_SHORT 8'h08
`define HFC_LEN_PARAM 8'h48
`define HFC_POS_AREA 3'h2
`define HFC_POS_BLOCK 3'h4
`define HFC_POS_OFS 3'h5
`define HFC_POS_CNT 3'h6
`define HFC_POS_LEN 3'h6
`define HFC_POS_STATUS 3'h2
`define HFC_LAST_BYTE 3'h7
`define HFC_SET_LAST_STEP 4'h9
`define HFC_GET_FIRST_IN 4'h3
`define HFC_GET_DATA_STEP 4'h4
`define HFC_GET_LAST_STEP 4'hb
`define HFC_ST_COMPLETE 8'h03
`define HFC_ST_SOFT_RESET 8'h04
`define HFC_ST_HARD_RESET 8'h05
`define HFC_RST_STATUS 8'h00
`endif

// >>> shared/hfc_pkg.sv
package hfc_pkg;
    typedef enum logic [2:0] {
        HFC_OP_RESET = 3'h0,
        HFC_OP_RESTORE = 3'h1,
        HFC_OP_SET_NUM = 3'h2,
        HFC_OP_GET_NUM = 3'h3,
        HFC_OP_STATUS = 3'h4
    } hfc_op_t;
    typedef enum logic [1:0] {
        HFC_STG_SETUP = 2'h0,
        HFC_STG_OUT = 2'h1,
        HFC_STG_IN = 2'h2,
        HFC_STG_END = 2'h3
    } hfc_stage_t;
    typedef enum logic [4:0] {
        HFC_IDLE = 5'h01,
        HFC_SEND = 5'h02,
        HFC_WAIT = 5'h04,
        HFC_RECV = 5'h08,
        HFC_FINISH = 5'h10
    } hfc_state_t;
endpackage

// >>> design/hfc_host.sv
`timescale 1ns/1ps
`include "hfc_consts.svh"
module hfc_host #(
    parameter int STAGE_BYTES = 8 // bytes per control stage
) (
    input wire logic clk, // 125 MHz
    input wire logic rst, // sync, active high
    input wire logic ce, // clock enable
    input wire logic cmd_valid, // user command request
    output logic cmd_ready, // idle, command taken
    input wire logic [2:0] cmd_op, // hfc_op_t code
    input wire logic [7:0] cmd_reset_kind, // reset kind byte
    input wire logic [31:0] cmd_number, // number to store
    output logic done, // one-cycle completion pulse
    output logic stalled, // last command stalled
    output logic [31:0] rd_number, // number read back
    output logic [7:0] status_code, // last command status
    output logic recal_needed, // calibration lost
    input wire logic recal_clear, // user recalibrated
    output logic tx_valid, // stage byte valid
    input wire logic tx_ready, // core takes byte
    output logic [7:0] tx_data, // stage byte
    output logic tx_setup, // byte belongs to setup stage
    output logic tx_last, // last byte of stage
    output logic in_req, // run an in data stage
    input wire logic rx_valid, // in byte from device
    input wire logic [7:0] rx_data, // in byte
    input wire logic stage_ack, // stage acknowledged
    input wire logic stage_stall // endpoint 0 stalled
);
    generate
        if (STAGE_BYTES != 8) begin : g_bad_stage
            $error("hfc_host serves only eight-byte stages");
        end
    endgenerate

    function automatic hfc_pkg::hfc_stage_t stage_kind(input logic [2:0] op,
                                                      input logic [3:0] st);
        hfc_pkg::hfc_stage_t k;
        k = hfc_pkg::HFC_STG_END;
        case (op)
            hfc_pkg::HFC_OP_RESET, hfc_pkg::HFC_OP_RESTORE: begin
                if (st == 4'h0) k = hfc_pkg::HFC_STG_SETUP;
                else if (st == 4'h1) k = hfc_pkg::HFC_STG_OUT;
            end
            hfc_pkg::HFC_OP_SET_NUM: begin
                if (st == 4'h0) k = hfc_pkg::HFC_STG_SETUP;
                else if (st <= `HFC_SET_LAST_STEP) k = hfc_pkg::HFC_STG_OUT;
            end
            hfc_pkg::HFC_OP_GET_NUM: begin
                if (st == 4'h0 || st == 4'h2) k = hfc_pkg::HFC_STG_SETUP;
                else if (st == 4'h1) k = hfc_pkg::HFC_STG_OUT;
                else if (st <= `HFC_GET_LAST_STEP) k = hfc_pkg::HFC_STG_IN;
            end
            hfc_pkg::HFC_OP_STATUS: begin
                if (st == 4'h0) k = hfc_pkg::HFC_STG_SETUP;
                else if (st == 4'h1) k = hfc_pkg::HFC_STG_IN;
            end
            default: k = hfc_pkg::HFC_STG_END;
        endcase
        return k;
    endfunction

    // setup packet, index always zero, length high byte zero
    function automatic logic [7:0] setup_byte(input logic [7:0] rt, input logic [7:0] rq,
                                              input logic [7:0] vlo, input logic [7:0] len,
                                              input logic [2:0] i);
        logic [7:0] b;
        b = 8'h00;
        case (i)
            3'h0: b = rt;
            3'h1: b = rq;
            3'h2: b = vlo;
            3'h3: b = `HFC_VAL_HI_FEATURE;
            `HFC_POS_LEN: b = len;
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // parameter header: nonvolatile area, number block, offset zero
    function automatic logic [7:0] param_hdr(input logic [7:0] tag, input logic [7:0] sub,
                                             input logic [2:0] i);
        logic [7:0] b;
        b = 8'h00;
        case (i)
            3'h0: b = tag;
            3'h1: b = sub;
            `HFC_POS_AREA: b = `HFC_AREA_NV;
            `HFC_POS_BLOCK: b = `HFC_BLOCK_NUM;
            `HFC_POS_OFS: b = `HFC_BLOCK_OFS;
            `HFC_POS_CNT: b = `HFC_VALID_CNT;
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    function automatic logic [7:0] stage_byte(input logic [2:0] op, input logic [3:0] st,
                                              input logic [2:0] i, input logic [7:0] kind,
                                              input logic [31:0] num);
        logic [7:0] b;
        b = 8'h00;
        case (op)
            hfc_pkg::HFC_OP_RESET: begin
                if (st == 4'h0) begin
                    b = setup_byte(`HFC_RT_SET, `HFC_RQ_SET, `HFC_TAG_CMD,
                                   `HFC_LEN_SHORT, i);
                end else if (i == 3'h0) begin
                    b = `HFC_TAG_CMD;
                end else if (i == 3'h1) begin
                    b = `HFC_SUB_RESET;
                end else if (i == 3'h2) begin
                    b = kind;
                end
            end
            hfc_pkg::HFC_OP_RESTORE: begin
                if (st == 4'h0) begin
                    b = setup_byte(`HFC_RT_SET, `HFC_RQ_SET, `HFC_TAG_CMD,
                                   `HFC_LEN_SHORT, i);
                end else if (i == 3'h0) begin
                    b = `HFC_TAG_CMD;
                end else if (i == 3'h1) begin
                    b = `HFC_SUB_DEFAULTS;
                end
            end
            hfc_pkg::HFC_OP_SET_NUM: begin
                if (st == 4'h0) begin
                    b = setup_byte(`HFC_RT_SET, `HFC_RQ_SET, `HFC_TAG_PARAM,
                                   `HFC_LEN_PARAM, i);
                end else if (st == 4'h1) begin
                    b = param_hdr(`HFC_TAG_PARAM, `HFC_SUB_SET_PARAM, i);
                end else if (st == 4'h2 && i < 3'h4) begin
                    b = num[{i[1:0], 3'h0} +: 8];
                end
            end
            hfc_pkg::HFC_OP_GET_NUM: begin
                if (st == 4'h0) begin
                    b = setup_byte(`HFC_RT_SET, `HFC_RQ_SET, `HFC_TAG_CMD,
                                   `HFC_LEN_SHORT, i);
                end else if (st == 4'h1) begin
                    b = param_hdr(`HFC_TAG_CMD, `HFC_SUB_SEL_PARAM, i);
                end else if (st == 4'h2) begin
                    b = setup_byte(`HFC_RT_GET, `HFC_RQ_GET, `HFC_TAG_PARAM,
                                   `HFC_LEN_PARAM, i);
                end
            end
            hfc_pkg::HFC_OP_STATUS: begin
                b = setup_byte(`HFC_RT_GET, `HFC_RQ_GET, `HFC_TAG_STATUS,
                               `HFC_LEN_SHORT, i);
            end
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    hfc_pkg::hfc_state_t state, next_state;
    logic [2:0] op, next_op;
    logic [3:0] step, next_step;
    logic [2:0] bi, next_bi;
    logic [7:0] kind, next_kind;
    logic [31:0] num, next_num;
    logic [7:0] next_tx_data;
    logic next_stalled;
    logic [31:0] next_rd_number;
    logic [7:0] next_status_code;
    logic next_recal_needed;
    hfc_pkg::hfc_stage_t cur_kind, new_kind;

    assign cur_kind = stage_kind(op, step);
    assign cmd_ready = (state == hfc_pkg::HFC_IDLE);
    assign tx_valid = (state == hfc_pkg::HFC_SEND);
    assign tx_setup = (cur_kind == hfc_pkg::HFC_STG_SETUP);
    assign tx_last = (bi == `HFC_LAST_BYTE);
    assign in_req = (state == hfc_pkg::HFC_RECV);
    assign done = (state == hfc_pkg::HFC_FINISH);

    always_comb begin
        next_state = state;
        next_op = op;
        next_step = step;
        next_bi = bi;
        next_kind = kind;
        next_num = num;
        next_stalled = stalled;
        next_rd_number = rd_number;
        next_status_code = status_code;
        next_recal_needed = recal_needed & ~recal_clear;
        new_kind = hfc_pkg::HFC_STG_END;
        case (state)
            hfc_pkg::HFC_IDLE: begin
                if (cmd_valid) begin
                    next_op = cmd_op;
                    next_kind = cmd_reset_kind;
                    next_num = cmd_number;
                    next_step = 4'h0;
                    next_bi = 3'h0;
                    next_stalled = 1'b0;
                    new_kind = stage_kind(cmd_op, 4'h0);
                    next_state = hfc_pkg::HFC_SEND;
                    if (new_kind == hfc_pkg::HFC_STG_END) next_state = hfc_pkg::HFC_FINISH;
                end
            end
            hfc_pkg::HFC_SEND: begin
                if (tx_ready) begin
                    if (bi == `HFC_LAST_BYTE) next_state = hfc_pkg::HFC_WAIT;
                    else next_bi = bi + 3'h1;
                end
            end
            hfc_pkg::HFC_WAIT, hfc_pkg::HFC_RECV: begin
                if (state == hfc_pkg::HFC_RECV && rx_valid) begin
                    if (op == hfc_pkg::HFC_OP_GET_NUM && step == `HFC_GET_DATA_STEP &&
                        bi < 3'h4) begin
                        next_rd_number[{bi[1:0], 3'h0} +: 8] = rx_data;
                    end
                    if (op == hfc_pkg::HFC_OP_STATUS && bi == `HFC_POS_STATUS) begin
                        next_status_code = rx_data;
                    end
                    if (bi != `HFC_LAST_BYTE) next_bi = bi + 3'h1;
                end
                if (stage_stall) begin
                    next_stalled = 1'b1;
                    next_state = hfc_pkg::HFC_FINISH;
                end else if (stage_ack) begin
                    next_step = step + 4'h1;
                    next_bi = 3'h0;
                    new_kind = stage_kind(op, step + 4'h1);
                    case (new_kind)
                        hfc_pkg::HFC_STG_SETUP, hfc_pkg::HFC_STG_OUT:
                            next_state = hfc_pkg::HFC_SEND;
                        hfc_pkg::HFC_STG_IN: next_state = hfc_pkg::HFC_RECV;
                        default: next_state = hfc_pkg::HFC_FINISH;
                    endcase
                end
            end
            hfc_pkg::HFC_FINISH: begin
                if (op == hfc_pkg::HFC_OP_RESTORE && !stalled) begin
                    next_recal_needed = 1'b1;
                end
                next_state = hfc_pkg::HFC_IDLE;
            end
            default: next_state = hfc_pkg::HFC_IDLE;
        endcase
        next_tx_data = stage_byte(next_op, next_step, next_bi, next_kind, next_num);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= hfc_pkg::HFC_IDLE;
            op <= 3'h0;
            step <= 4'h0;
            bi <= 3'h0;
            kind <= 8'h00;
            num <= 32'h0000_0000;
            tx_data <= 8'h00;
            stalled <= 1'b0;
            rd_number <= 32'h0000_0000;
            status_code <= `HFC_RST_STATUS;
            recal_needed <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            op <= next_op;
            step <= next_step;
            bi <= next_bi;
            kind <= next_kind;
            num <= next_num;
            tx_data <= next_tx_data;
            stalled <= next_stalled;
            rd_number <= next_rd_number;
            status_code <= next_status_code;
            recal_needed <= next_recal_needed;
        end
    end
endmodule // hfc_host

// >>> dv/hfc_host_properties.sv
`timescale 1ns/1ps
module hfc_host_properties (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic ce, // enable
    input wire logic cmd_valid, // request
    input wire logic cmd_ready, // idle
    input wire logic [2:0] cmd_op, // code
    input wire logic done, // end pulse
    input wire logic stalled, // stall flag
    input wire logic tx_valid, // byte valid
    input wire logic tx_ready, // byte taken
    input wire logic [7:0] tx_data, // byte
    input wire logic tx_setup, // setup stage
    input wire logic tx_last, // last byte
    input wire logic in_req, // in stage
    input wire logic stage_ack, // ack
    input wire logic stage_stall // stall
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire take = cmd_valid && cmd_ready && ce;
    // bytes sent since the command was taken
    logic [2:0] op_seen;
    logic [6:0] bytes_seen;
    always_ff @(posedge clk) begin
        if (rst) begin
            op_seen <= 3'h0;
            bytes_seen <= 7'h00;
        end else if (take) begin
            op_seen <= cmd_op;
            bytes_seen <= 7'h00;
        end else if (tx_valid && tx_ready && ce) begin
            bytes_seen <= bytes_seen + 7'h01;
        end
    end
    property p_byte_total;
        done && !stalled |-> bytes_seen == (op_seen == 3'h2 ? 7'h50 : op_seen == 3'h3 ? 7'h18
            : op_seen == 3'h4 ? 7'h08 : op_seen < 3'h2 ? 7'h10 : 7'h00);
    endproperty
    a_byte_total: assert property (p_byte_total) else $error("wrong stage byte total");
    property p_set_first; take && cmd_op < 3'h4 |=> tx_valid && tx_setup && tx_data == 8'h21;
    endproperty
    a_set_first: assert property (p_set_first) else $error("bad set type");
    property p_get_first; take && cmd_op == 3'h4 |=> tx_valid && tx_setup && tx_data == 8'ha1;
    endproperty
    a_get_first: assert property (p_get_first) else $error("bad get type");
    property p_set_second; tx_valid && tx_ready && tx_setup && tx_data == 8'h21 |=> tx_data == 8'h09;
    endproperty
    a_set_second: assert property (p_set_second) else $error("bad set code");
    property p_get_second; tx_valid && tx_ready && tx_setup && tx_data == 8'ha1 |=> tx_data == 8'h01;
    endproperty
    a_get_second: assert property (p_get_second) else $error("bad get code");
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_hold: assert property (p_hold) else $error("byte not held");
    property p_stage_end; tx_valid && tx_ready && tx_last |=> !tx_valid;
    endproperty
    a_stage_end: assert property (p_stage_end) else $error("stage overrun");
    property p_in_after_ack; $rose(in_req) |-> $past(stage_ack);
    endproperty
    a_in_after_ack: assert property (p_in_after_ack) else $error("early in stage");
    property p_stall_abort; stage_stall && !cmd_ready && !tx_valid |-> ##[1:2] done ##1 stalled;
    endproperty
    a_stall_abort: assert property (p_stall_abort) else $error("stall not ended");
    property p_done_ready; done |=> cmd_ready && !done;
    endproperty
    a_done_ready: assert property (p_done_ready) else $error("not idle after done");
endmodule // hfc_host_properties
bind hfc_host hfc_host_properties u_props (.clk, .rst, .ce, .cmd_valid, .cmd_ready, .cmd_op,
    .done, .stalled, .tx_valid, .tx_ready, .tx_data, .tx_setup, .tx_last, .in_req, .stage_ack,
    .stage_stall);

// >>> dv/hfc_dev_model.sv
`timescale 1ns/1ps
module hfc_dev_model (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic slow, // halve byte rate
    input wire logic tx_valid, // byte valid
    output logic tx_ready, // byte taken
    input wire logic [7:0] tx_data, // byte
    input wire logic tx_setup, // setup stage
    input wire logic in_req, // in stage
    output logic rx_valid, // in byte valid
    output logic [7:0] rx_data, // in byte
    output logic stage_ack, // ack
    output logic stage_stall // stall
);
    logic [7:0] b [8];
    logic [7:0] su [8];
    logic [7:0] st, tag;
    logic [31:0] num;
    logic sf;
    int bi, ri, os, ist;
    task automatic answer(input logic ok);
        if (ok) stage_ack <= 1'b1;
        else begin
            stage_stall <= 1'b1;
            st = 8'h00;
        end
    endtask
    // unused trailing bytes of an out stage must be zero
    function automatic logic zeros_from(input int k);
        for (int j = k; j < 8; j++) if (b[j] != 8'h00) return 1'b0;
        return 1'b1;
    endfunction
    function automatic logic [7:0] in_byte(input int i);
        if (su[2] == 8'h06) return i == 2 ? st : (i == 0 ? 8'h06 : 8'h00);
        if (ist == 0) return (i == 0 || i == 4) ? 8'h05 : (i == 6 ? 8'h04 : 8'h00);
        if (ist == 1 && i < 4) return num[8*i +: 8];
        return 8'ha5;
    endfunction
    always @(posedge clk) begin
        stage_ack <= 1'b0;
        stage_stall <= 1'b0;
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (rst) begin
            bi = 0; ri = 0; st = 8'h00; num = 32'h0;
            tx_ready <= 1'b0;
            rx_data <= 8'h00;
        end else if (tx_valid && tx_ready) begin
            if (bi == 0) sf = tx_setup;
            b[bi] = tx_data;
            bi++;
            if (bi == 8 && sf) begin
                bi = 0; su = b; os = 0; ist = 0;
                answer(su[3] == 8'h03 && su[4] == 8'h00 && su[5] == 8'h00 && su[7] == 8'h00
                    && su[6] == ((su[2] == 8'h05) ? 8'h48 : 8'h08)
                    && ((su[0] == 8'h21 && su[1] == 8'h09 && su[2] inside {8'h03, 8'h05})
                    || (su[0] == 8'ha1 && su[1] == 8'h01 && su[2] inside {8'h05, 8'h06})));
            end else if (bi == 8) begin
                bi = 0;
                if (os == 0) begin
                    tag = b[0];
                    case ({b[0], b[1]})
                        16'h0307: begin
                            answer(b[2] == 8'h01 && zeros_from(3));
                            if (b[2] == 8'h01 && zeros_from(3)) st = 8'h04;
                        end
                        16'h0308: begin
                            answer(zeros_from(2));
                            if (zeros_from(2)) st = 8'h03;
                        end
                        16'h0302, 16'h0501: answer(b[2] == 8'h00 && b[3] == 8'h00
                            && b[4] == 8'h05 && b[5] == 8'h00 && b[6] == 8'h04
                            && b[7] == 8'h00);
                        default: answer(1'b0);
                    endcase
                end else begin
                    if (os == 1 && tag == 8'h05) begin
                        num = {b[3], b[2], b[1], b[0]};
                        st = 8'h03;
                    end
                    answer(1'b1);
                end
                os++;
            end
        end else if (ri == 9) ri = 0;
        else if (in_req) begin
            if (ri == 8) begin
                stage_ack <= 1'b1;
                ri = 9;
                ist++;
            end else begin
                rx_valid <= 1'b1;
                rx_data <= in_byte(ri);
                ri++;
            end
        end
    end
endmodule // hfc_dev_model

// >>> dv/hfc_host_tb.sv
`timescale 1ns/1ps
module hfc_host_tb;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, cmd_valid = 1'b0, recal_clear = 1'b0, slow = 1'b0;
    logic [2:0] cmd_op = 3'h0;
    logic [7:0] cmd_reset_kind = 8'h00;
    logic [31:0] cmd_number = 32'h0;
    logic cmd_ready, done, stalled, recal_needed, tx_valid, tx_ready, tx_setup, tx_last, in_req;
    logic rx_valid, stage_ack, stage_stall;
    logic [7:0] tx_data, rx_data, status_code;
    logic [31:0] rd_number;
    int num_errors = 0, samples_checked = 0, cycles = 0;
    hfc_host DUT (.clk, .rst, .ce, .cmd_valid, .cmd_ready, .cmd_op, .cmd_reset_kind, .cmd_number,
        .done, .stalled, .rd_number, .status_code, .recal_needed, .recal_clear, .tx_valid,
        .tx_ready, .tx_data, .tx_setup, .tx_last, .in_req, .rx_valid, .rx_data, .stage_ack,
        .stage_stall);
    hfc_dev_model u_dev (.clk, .rst, .slow, .tx_valid, .tx_ready, .tx_data, .tx_setup, .in_req,
        .rx_valid, .rx_data, .stage_ack, .stage_stall);
    initial forever #4 clk = ~clk;
    task automatic report_and_stop;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // called at a rising edge; returns one edge after done
    task automatic run(input logic [2:0] op, input logic [7:0] kind, input logic [31:0] n);
        cmd_op <= op;
        cmd_reset_kind <= kind;
        cmd_number <= n;
        cmd_valid <= 1'b1;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        do @(posedge clk); while (done !== 1'b1);
        @(posedge clk);
    endtask
    task automatic t_reset(input logic [7:0] kind, input logic bad, input logic [7:0] code);
        run(3'h0, kind, 32'h0);
        check(stalled, bad);
        run(3'h4, 8'h00, 32'h0);
        check(status_code, code);
    endtask
    task automatic t_restore;
        run(3'h1, 8'h00, 32'h0);
        check(stalled, 1'b0);
        check(recal_needed, 1'b1);
        ce <= 1'b0;
        recal_clear <= 1'b1;
        repeat (2) @(posedge clk);
        check(recal_needed, 1'b1);
        ce <= 1'b1;
        @(posedge clk);
        recal_clear <= 1'b0;
        @(posedge clk);
        check(recal_needed, 1'b0);
    endtask
    task automatic t_number;
        slow <= 1'b1;
        run(3'h2, 8'h00, 32'h1234_5678);
        check(stalled, 1'b0);
        run(3'h4, 8'h00, 32'h0);
        check(status_code, 8'h03);
        run(3'h3, 8'h00, 32'h0);
        check(stalled, 1'b0);
        check(rd_number, 32'h1234_5678);
        run(3'h4, 8'h00, 32'h0);
        check(status_code, 8'h03);
        slow <= 1'b0;
    endtask
    task automatic t_no_op;
        run(3'h5, 8'h00, 32'h0);
        check(stalled, 1'b0);
        check(status_code, 8'h03);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset(8'h01, 1'b0, 8'h04);
        t_reset(8'h02, 1'b1, 8'h00);
        t_restore();
        t_number();
        t_no_op();
        t_reset(8'h01, 1'b0, 8'h04);
        report_and_stop();
    end
endmodule // hfc_host_tb
